/* src/pll_divider_config_defines.svh */
`ifndef PLL_DIVIDER_CONFIG_DEFINES_SVH
`define PLL_DIVIDER_CONFIG_DEFINES_SVH
// Register indices; each register is one aligned word, byte address = 4 * index
`define REFDIV_LOW_IDX 7'h54
`define REFDIV_HIGH_IDX 7'h55
`define FBDIV_LOW_IDX 7'h56
`define FBDIV_HIGH_IDX 7'h57
`define PUMP_IDX 7'h58
`define ENABLE_IDX 7'h59
// Reset values
`define REFDIV_LOW_RST 8'h00
`define REFDIV_HIGH_RST 8'h48
`define FBDIV_LOW_RST 8'h78
`define FBDIV_HIGH_RST 8'h40
`define PUMP_RST 8'h12
`define ENABLE_RST 8'h41
// Field positions
`define REFDIV_HIGH_LSB 0
`define FBDIV_HIGH_LSB 0
`define PUMP_CODE_LSB 0
`define REFDIV_EN_BIT 4
// Pump current step in microamps
`define PUMP_STEP_UA 9'h019
`endif

/* src/pll_divider_config_pkg.sv */
package pll_divider_config_pkg;
   // Register file contents
   typedef struct packed {
      logic [7:0] refLow;
      logic [7:0] refHigh;
      logic [7:0] fbLow;
      logic [7:0] fbHigh;
      logic [7:0] pump;
      logic [7:0] enable;
   } regs_s;
   // Bus slave phases
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WRESP = 3'b010,
      BUS_RRESP = 3'b100
   } bus_e;
endpackage

/* src/clock_divider.sv */
`timescale 1ns/100ps
`default_nettype none
// Generic integer divider with terminal-count reload
module clock_divider #(
   parameter int W = 10
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [W-1:0] ratio,
   output logic clkOut
);
   // ***************************************
   // State
   // ***************************************
   typedef struct packed {
      logic [W-1:0] count; // Cycles into current period
      logic [W-1:0] active; // Ratio in force this period
      logic out; // Divided clock
   } state_s;
   state_s state_q;
   state_s state_d;
   logic [W-1:0] eff;
   assign clkOut = state_q.out;
   // Next state; ratio below two means a toggle every core cycle
   always_comb begin
      state_d = state_q;
      eff = (state_q.active < W'(2)) ? W'(1) : state_q.active;
      if (state_q.count >= eff - W'(1)) begin
         // Terminal count: adopt new ratio only here, no runt pulse
         state_d.count = '0;
         state_d.active = ratio;
         state_d.out = 1'b1;
      end else begin
         state_d.count = state_q.count + W'(1);
         if (state_q.count + W'(1) >= (eff >> 1)) begin
            state_d.out = 1'b0;
         end
      end
      if (eff == W'(1)) begin
         // Ratio one: follow a toggle at core rate
         state_d.out = ~state_q.out;
      end
   end
   // Register stage
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end
endmodule
`default_nettype wire

/* src/pll_divider_config.sv */
// Decided for this implementation: the AXI4-Lite interface to the registers.
`include "pll_divider_config_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module pll_divider_config (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [8:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [8:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic refClkDiv,
   output logic fbClkDiv,
   output logic [3:0] pumpCurrentCode,
   output logic [8:0] pumpCurrentUa
);
   // ***************************************
   // State
   // ***************************************
   typedef struct packed {
      pll_divider_config_pkg::regs_s regs; // Register file
      pll_divider_config_pkg::bus_e wPhase; // Write channel phase
      pll_divider_config_pkg::bus_e rPhase; // Read channel phase
      logic awHave; // Address captured
      logic [8:0] awAddr; // Byte address, four times the index
      logic wHave; // Data captured
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic [1:0] bResp;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic awReady;
      logic wReady;
      logic arReady;
      logic [3:0] pumpCode;
      logic [8:0] pumpUa;
   } state_s;
   state_s state_q;
   state_s state_d;
   // Decoded divide ratios
   logic [9:0] refRatio;
   logic [11:0] fbRatio;
   logic refDivOut;
   // ***************************************
   // Ratio assembly
   // ***************************************
   // Bypass forces ratio one regardless of code
   always_comb begin
      refRatio = {state_q.regs.refHigh[`REFDIV_HIGH_LSB +: 2],
                  state_q.regs.refLow};
      if (!state_q.regs.enable[`REFDIV_EN_BIT]) begin
         refRatio = 10'h001;
      end
      fbRatio = {state_q.regs.fbHigh[`FBDIV_HIGH_LSB +: 4], state_q.regs.fbLow};
   end
   // Reference divider; code two is undefined and simply divides by two
   clock_divider #(.W(10)) refDivider (
      .core_clk(core_clk),
      .rstn(rstn),
      .ratio(refRatio),
      .clkOut(refDivOut)
   );
   // Feedback prescaler
   clock_divider #(.W(12)) fbDivider (
      .core_clk(core_clk),
      .rstn(rstn),
      .ratio(fbRatio),
      .clkOut(fbClkDiv)
   );
   // ***************************************
   // Read mux
   // ***************************************
   function automatic logic [7:0] readByte(input pll_divider_config_pkg::regs_s r,
                                           input logic [8:0] a, output logic ok);
      // Unaligned byte addresses are refused
      ok = (a[1:0] == 2'b00);
      unique case (a[8:2])
         `REFDIV_LOW_IDX: readByte = r.refLow;
         `REFDIV_HIGH_IDX: readByte = r.refHigh;
         `FBDIV_LOW_IDX: readByte = r.fbLow;
         `FBDIV_HIGH_IDX: readByte = r.fbHigh;
         `PUMP_IDX: readByte = r.pump;
         `ENABLE_IDX: readByte = r.enable;
         default: begin
            readByte = 8'h00;
            ok = 1'b0;
         end
      endcase
   endfunction
   // ***************************************
   // Next-state logic
   // ***************************************
   always_comb begin
      logic ok;
      logic [7:0] rb;
      logic [7:0] wb;
      ok = 1'b0;
      rb = 8'h00;
      wb = 8'h00;
      state_d = state_q;
      // Write address and data may arrive in either order
      if (state_q.awReady && s_axi_awvalid) begin
         state_d.awHave = 1'b1;
         state_d.awAddr = s_axi_awaddr;
         state_d.awReady = 1'b0;
      end
      if (state_q.wReady && s_axi_wvalid) begin
         state_d.wHave = 1'b1;
         state_d.wData = s_axi_wdata;
         state_d.wStrb = s_axi_wstrb;
         state_d.wReady = 1'b0;
      end
      unique case (state_q.wPhase)
         pll_divider_config_pkg::BUS_IDLE: begin
            if (state_q.awHave && state_q.wHave) begin
               // Only byte lane 0 carries register data
               wb = state_q.wData[7:0];
               state_d.bResp = 2'b00;
               if (state_q.awAddr[1:0] != 2'b00) begin
                  state_d.bResp = 2'b10;
               end else if (state_q.wStrb[0]) begin
                  unique case (state_q.awAddr[8:2])
                     `REFDIV_LOW_IDX: state_d.regs.refLow = wb;
                     `REFDIV_HIGH_IDX: state_d.regs.refHigh = wb;
                     `FBDIV_LOW_IDX: state_d.regs.fbLow = wb;
                     `FBDIV_HIGH_IDX: state_d.regs.fbHigh = wb;
                     `PUMP_IDX: state_d.regs.pump = wb;
                     `ENABLE_IDX: state_d.regs.enable = {1'b0, wb[6:0]};
                     default: state_d.bResp = 2'b10;
                  endcase
               end
               state_d.awHave = 1'b0;
               state_d.wHave = 1'b0;
               state_d.wPhase = pll_divider_config_pkg::BUS_WRESP;
            end
         end
         pll_divider_config_pkg::BUS_WRESP: begin
            if (s_axi_bready) begin
               state_d.wPhase = pll_divider_config_pkg::BUS_IDLE;
               state_d.awReady = 1'b1;
               state_d.wReady = 1'b1;
            end
         end
         default: state_d.wPhase = pll_divider_config_pkg::BUS_IDLE;
      endcase
      unique case (state_q.rPhase)
         pll_divider_config_pkg::BUS_IDLE: begin
            if (state_q.arReady && s_axi_arvalid) begin
               rb = readByte(state_q.regs, s_axi_araddr, ok);
               state_d.rData = {24'h00_0000, rb};
               state_d.rResp = ok ? 2'b00 : 2'b10;
               state_d.arReady = 1'b0;
               state_d.rPhase = pll_divider_config_pkg::BUS_RRESP;
            end
         end
         pll_divider_config_pkg::BUS_RRESP: begin
            if (s_axi_rready) begin
               state_d.arReady = 1'b1;
               state_d.rPhase = pll_divider_config_pkg::BUS_IDLE;
            end
         end
         default: state_d.rPhase = pll_divider_config_pkg::BUS_IDLE;
      endcase
      // Pump current: (code + 1) steps of 25 uA
      state_d.pumpCode = state_q.regs.pump[`PUMP_CODE_LSB +: 4];
      state_d.pumpUa = 9'({5'h00, state_q.pumpCode} + 9'h001) * `PUMP_STEP_UA;
   end
   // ***************************************
   // Registers
   // ***************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_q.regs.refLow <= `REFDIV_LOW_RST;
         state_q.regs.refHigh <= `REFDIV_HIGH_RST;
         state_q.regs.fbLow <= `FBDIV_LOW_RST;
         state_q.regs.fbHigh <= `FBDIV_HIGH_RST;
         state_q.regs.pump <= `PUMP_RST;
         state_q.regs.enable <= `ENABLE_RST;
         state_q.wPhase <= pll_divider_config_pkg::BUS_IDLE;
         state_q.rPhase <= pll_divider_config_pkg::BUS_IDLE;
         state_q.awHave <= 1'b0;
         state_q.awAddr <= 9'h000;
         state_q.wHave <= 1'b0;
         state_q.wData <= 32'h0000_0000;
         state_q.wStrb <= 4'h0;
         state_q.bResp <= 2'b00;
         state_q.rData <= 32'h0000_0000;
         state_q.rResp <= 2'b00;
         state_q.awReady <= 1'b1;
         state_q.wReady <= 1'b1;
         state_q.arReady <= 1'b1;
         state_q.pumpCode <= 4'h2;
         state_q.pumpUa <= 9'h04b;
      end else begin
         state_q <= state_d;
      end
   end
   // Reference output retimed through one more flop, one cycle behind the divider flop
   logic refOut_q;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         refOut_q <= 1'b0;
      end else begin
         refOut_q <= refDivOut;
      end
   end
   // Outputs
   assign refClkDiv = refOut_q;
   assign s_axi_awready = state_q.awReady;
   assign s_axi_wready = state_q.wReady;
   // One-hot phase bits are flops themselves
   assign s_axi_bvalid = state_q.wPhase[1];
   assign s_axi_bresp = state_q.bResp;
   assign s_axi_arready = state_q.arReady;
   assign s_axi_rvalid = state_q.rPhase[2];
   assign s_axi_rdata = state_q.rData;
   assign s_axi_rresp = state_q.rResp;
   assign pumpCurrentCode = state_q.pumpCode;
   assign pumpCurrentUa = state_q.pumpUa;
endmodule
`default_nettype wire

/* dv/pll_divider_config_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************
// Bus and pump checker
// ****************
module pll_divider_config_asserts (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] pumpCurrentCode,
   input wire logic [8:0] pumpCurrentUa
);
   // One domain, so clock and reset are declared once
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // Current follows the code one cycle later, 25 uA a step
   pump_ua_a: assert property (pumpCurrentUa == (9'($past(pumpCurrentCode)) + 9'h001) * 9'h019)
      else $error("pump current off");
   // Responses stand until taken
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("rvalid dropped");
   // No new request taken while an answer is pending; a read is answered the next cycle
   w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken early");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken early");
   r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   // Register bytes sit in bits 7:0, upper bits read zero
   r_upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   b_code_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
      else $error("bad write response");
endmodule
bind pll_divider_config pll_divider_config_asserts chk (.*);
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic core_clk, rstn, awV, wV, bR, arV, rR, awRdy, wRdy, bV, arRdy, rV, refClkDiv, fbClkDiv;
   logic [8:0] awA, arA;
   logic [31:0] wD, rD;
   logic [3:0] wS, pumpCode;
   logic [1:0] bResp, rResp;
   logic [8:0] pumpUa;
   logic [11:0] code;
   int fail_count = 0;
   int total_checks = 0;
   pll_divider_config DUT (.core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(awA),
      .s_axi_awvalid(awV), .s_axi_awready(awRdy), .s_axi_wdata(wD), .s_axi_wstrb(wS),
      .s_axi_wvalid(wV), .s_axi_wready(wRdy), .s_axi_bresp(bResp), .s_axi_bvalid(bV),
      .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arRdy),
      .s_axi_rdata(rD), .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rR),
      .refClkDiv(refClkDiv), .fbClkDiv(fbClkDiv), .pumpCurrentCode(pumpCode),
      .pumpCurrentUa(pumpUa));
   // ****************
   // Helpers
   // ****************
   // Codes below two give ratio one, modelled as a toggle: period of two cycles
   function automatic int expPeriod(input int c);
      return (c < 2) ? 2 : c;
   endfunction
   task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Write offers address and data together, drops each once taken
   task automatic busWrite(input logic [8:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      awA <= a; wD <= 32'(d); awV <= 1'b1; wV <= 1'b1; bR <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge core_clk);
         if (awRdy) awV <= 1'b0;
         if (wRdy) wV <= 1'b0;
         if (bV) break;
      end
      bR <= 1'b0;
      if (n == 50) begin fail_count++; results(); end
      checkVal(32'(bResp), 32'(er));
      // Let an edge pass so a following call never reassigns bready at once
      @(posedge core_clk);
   endtask
   task automatic busRead(input logic [8:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      arA <= a; arV <= 1'b1; rR <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge core_clk);
         if (arRdy) arV <= 1'b0;
         if (rV) break;
      end
      rR <= 1'b0;
      if (n == 50) begin fail_count++; results(); end
      checkVal(32'(rResp), 32'(er));
      if (er == 2'b00) checkVal(rD, ed);
      @(posedge core_clk);
   endtask
   // Full period, rise to rise; the first rise skipped since a new ratio waits for terminal count
   task automatic checkPeriod(input logic fb, input int en);
      logic prev;
      logic cur;
      int n;
      int t;
      int edges;
      n = 0;
      t = 0;
      edges = 0;
      prev = fb ? fbClkDiv : refClkDiv;
      while (edges < 3 && t < 20000) begin
         @(posedge core_clk);
         t++;
         n++;
         cur = fb ? fbClkDiv : refClkDiv;
         if (cur === 1'b1 && prev === 1'b0) begin
            edges++;
            if (edges == 2) n = 0;
         end
         prev = cur;
      end
      if (edges < 3) begin fail_count++; results(); end
      checkVal(32'(n), 32'(en));
   endtask
   // ****************
   // Clock, watchdog, sequence
   // ****************
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      repeat (100000) @(posedge core_clk);
      fail_count++;
      results();
   end
   initial begin
      rstn = 1'b0; awV = 1'b0; wV = 1'b0; bR = 1'b0; arV = 1'b0; rR = 1'b0;
      awA = 9'h000; arA = 9'h000; wD = 32'h0000_0000; wS = 4'hF; code = $urandom(80);
      repeat (10) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      // Byte addresses are four times the register index
      busRead(9'h158, 32'h0000_0078, 2'b00);
      busRead(9'h15C, 32'h0000_0040, 2'b00);
      checkPeriod(1'b1, 120);
      busWrite(9'h150, 8'h05, 2'b00);
      checkPeriod(1'b0, expPeriod(1));
      $display("test reset done");
      // Feedback codes, factory nibble kept at its reset value
      for (int i = 0; i < 7; i++) begin
         code = (i < 4) ? 12'(i == 3 ? 4095 : i) : 12'($urandom_range(300, 3));
         busWrite(9'h158, code[7:0], 2'b00);
         busWrite(9'h15C, {4'h4, code[11:8]}, 2'b00);
         busRead(9'h15C, 32'({4'h4, code[11:8]}), 2'b00);
         checkPeriod(1'b1, expPeriod(int'(code)));
      end
      $display("test feedback done");
      // Enable bit set; bit 7 is unimplemented and reads zero
      busWrite(9'h164, 8'hD1, 2'b00);
      busRead(9'h164, 32'h0000_0051, 2'b00);
      for (int i = 0; i < 5; i++) begin
         // Code two is never written by software
         code = (i < 3) ? 12'(i == 2 ? 1023 : i) : 12'($urandom_range(200, 3));
         busWrite(9'h150, code[7:0], 2'b00);
         busWrite(9'h154, {6'h12, code[9:8]}, 2'b00);
         checkPeriod(1'b0, expPeriod(int'(code)));
      end
      $display("test reference done");
      for (int i = 0; i < 6; i++) begin
         code = (i < 2) ? 12'(i * 15) : 12'($urandom_range(15, 0));
         busWrite(9'h160, {4'h1, code[3:0]}, 2'b00);
         repeat (2) @(posedge core_clk);
         checkVal(32'(pumpCode), 32'(code[3:0]));
         checkVal(32'(pumpUa), 32'((code[3:0] + 1) * 25));
      end
      // Unmapped and unaligned places refused both ways
      busWrite(9'h180, 8'hAA, 2'b10);
      busRead(9'h180, 32'h0000_0000, 2'b10);
      busWrite(9'h159, 8'h11, 2'b10);
      busRead(9'h159, 32'h0000_0000, 2'b10);
      $display("test pump and unmapped done");
      results();
   end
endmodule
`default_nettype wire
